// ===== verilog/etc_exposure_ctrl.sv
// exposure timing, trigger qualification and status outputs
// assumes trigger pins synchronous to mclk; readout length given in cycles
`timescale 1ns/1ps
`include "etc_defs.svh"
module etc_exposure_ctrl
   import etc_pkg::*;
#(
   parameter int TRIG_DLY_CYC = `ETC_TRIG_DLY_US * `ETC_CLK_MHZ,
   parameter int RISE_DLY_CYC = `ETC_RISE_DLY_US * `ETC_CLK_MHZ,
   parameter int FALL_DLY_CYC = `ETC_FALL_DLY_US * `ETC_CLK_MHZ
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rstn,
   // configuration
   input  wire etc_pkg::etc_cfg_type cfg,
   // readout length of the current area of interest, in cycles
   input  wire logic [23:0]        readout_cycles,
   // trigger inputs
   input  wire logic [3:0]         hw_trigger_in,
   // status
   output logic [3:0]              ports_out,
   output logic                    capture_permit_out,
   output logic                    exposure_active_out,
   output logic                    exposing,
   output logic                    reading
);
   import etc_pkg::*;

   // =========================================================
   // state
   typedef struct packed {
      etc_state_type st;
      logic          trig_prev;
      logic [15:0]   tick_cnt;
      logic [11:0]   step_cnt;
      logic [11:0]   mult;
      logic [15:0]   tbase;
      logic [15:0]   dly_cnt;
      logic          min_done;
      logic [23:0]   rd_cnt;
      logic          rd_busy;
      logic          permit;
      logic [3:0]    ports;
      logic          active;
      logic          expo;
   } etc_ctl_state_type;

   etc_ctl_state_type s_q, s_d;
   logic trig_lvl, trig_act, trig_edge, active_dly, exp_end;
   logic [11:0] eff_mult;
   // active output windows, one extra cycle for the output register
   localparam int ACT_RISE_LO = RISE_DLY_CYC;
   localparam int ACT_RISE_HI = RISE_DLY_CYC + 1;
   localparam int ACT_FALL_LO = FALL_DLY_CYC;
   localparam int ACT_FALL_HI = FALL_DLY_CYC + 1;

   // =========================================================
   // trigger source and edge
   assign trig_lvl  = hw_trigger_in[cfg.trig_source];
   assign trig_act  = trig_lvl ^ cfg.falling_edge;
   assign trig_edge = trig_act & ~s_q.trig_prev & cfg.trig_enable;
   // zero multiplier treated as the minimum
   assign eff_mult  = (cfg.multiplier < `ETC_MULT_MIN) ? `ETC_MULT_MIN : cfg.multiplier;

   // =========================================================
   // active output delay
   etc_delay_line #(
      .RISE_CYC (RISE_DLY_CYC),
      .FALL_CYC (FALL_DLY_CYC)
   ) u_active_dly (
      .mclk      (mclk),
      .rstn      (rstn),
      .level_in  (s_q.st == etc_expose_s),
      .level_out (active_dly)
   );

   // =========================================================
   // next state
   always_comb begin
      s_d = s_q;
      exp_end = 1'b0;
      s_d.trig_prev = trig_act;
      s_d.active = active_dly;
      if (s_q.rd_busy) begin
         if (s_q.rd_cnt <= 24'h000001) s_d.rd_busy = 1'b0;
         s_d.rd_cnt = s_q.rd_cnt - 24'h000001;
      end
      unique case (s_q.st)
         etc_idle_type_s: begin
            if (trig_edge && s_q.permit) begin
               s_d.st = etc_delay_s;
               s_d.dly_cnt = 16'h0000;
               s_d.mult = eff_mult;
               s_d.tbase = cfg.tbase_cycles;
            end
         end
         etc_delay_s: begin
            s_d.dly_cnt = s_q.dly_cnt + 16'h0001;
            if (s_q.dly_cnt >= 16'(TRIG_DLY_CYC - 1)) begin
               s_d.st = etc_expose_s;
               s_d.tick_cnt = 16'h0000;
               s_d.step_cnt = 12'h000;
               s_d.min_done = 1'b0;
            end
         end
         etc_expose_s: begin
            if (!s_q.min_done) begin
               s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
               if (s_q.tick_cnt >= s_q.tbase - 16'h0001) begin
                  s_d.tick_cnt = 16'h0000;
                  s_d.step_cnt = s_q.step_cnt + 12'h001;
                  if (s_q.step_cnt >= s_q.mult - 12'h001) s_d.min_done = 1'b1;
               end
            end
            // end in the cycle the last tick completes, so length is exact
            if ((s_q.min_done || s_d.min_done) && !(cfg.level_mode && trig_act)) begin
               exp_end = 1'b1;
               s_d.st = etc_idle_type_s;
               s_d.rd_busy = 1'b1;
               s_d.rd_cnt = readout_cycles;
            end
         end
         default: s_d.st = etc_idle_type_s;
      endcase
      s_d.expo = (s_d.st == etc_expose_s);
      // permit after exposure; a new exposure must last at least as long as the remaining readout
      s_d.permit = cfg.trig_enable && (s_d.st == etc_idle_type_s) &&
                   (!s_d.rd_busy || ({12'h000, eff_mult} * {8'h00, cfg.tbase_cycles} >=
                   {16'h0000, s_d.rd_cnt}));
      s_d.ports = 4'h0;
      s_d.ports[cfg.permit_port] = s_d.permit;
      s_d.ports[cfg.active_port] = s_d.ports[cfg.active_port] | active_dly;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) s_q <= '0;
      else s_q <= s_d;
   end

   assign ports_out           = s_q.ports;
   assign capture_permit_out  = s_q.permit;
   assign exposure_active_out = s_q.active;
   assign exposing            = s_q.expo;
   assign reading             = s_q.rd_busy;

   // =========================================================
   // checks
   int unsigned lat_cnt;
   always_ff @(posedge mclk) begin
      if (!rstn || s_q.st != etc_delay_s) lat_cnt <= 0;
      else lat_cnt <= lat_cnt + 1;
   end

   sequence s_start;
      s_q.st == etc_delay_s && $past(s_q.st) == etc_idle_type_s;
   endsequence

   property p_ignore;
      @(posedge mclk) disable iff (!rstn) (trig_edge && !s_q.permit && s_q.st == etc_idle_type_s) |=> s_q.st == etc_idle_type_s;
   endproperty
   a_ignore: assert property (p_ignore) else $error("trigger taken while permit low");

   property p_delay;
      @(posedge mclk) disable iff (!rstn) (s_q.st == etc_delay_s && $past(s_q.st) == etc_delay_s && s_d.st == etc_expose_s) |-> lat_cnt == TRIG_DLY_CYC - 1;
   endproperty
   a_delay: assert property (p_delay) else $error("trigger delay wrong");

   property p_permit_drop;
      @(posedge mclk) disable iff (!rstn) s_start |-> !capture_permit_out;
   endproperty
   a_permit_drop: assert property (p_permit_drop) else $error("permit high during capture");

   property p_no_permit_off;
      @(posedge mclk) disable iff (!rstn) !cfg.trig_enable |=> !capture_permit_out;
   endproperty
   a_no_permit_off: assert property (p_no_permit_off) else $error("permit with trigger off");

   property p_route;
      @(posedge mclk) disable iff (!rstn) capture_permit_out |-> ports_out[cfg.permit_port] || $changed(cfg.permit_port);
   endproperty
   a_route: assert property (p_route) else $error("permit not routed");

   property p_read_start;
      @(posedge mclk) disable iff (!rstn) exp_end |=> reading || readout_cycles == 24'h000000;
   endproperty
   a_read_start: assert property (p_read_start) else $error("readout not started");

   property p_active_rise;
      @(posedge mclk) disable iff (!rstn) $rose(exposing) |-> ##[ACT_RISE_LO:ACT_RISE_HI] exposure_active_out;
   endproperty
   a_active_rise: assert property (p_active_rise) else $error("active rise late");

   property p_active_fall;
      @(posedge mclk) disable iff (!rstn) $fell(exposing) |-> ##[ACT_FALL_LO:ACT_FALL_HI] !exposure_active_out;
   endproperty
   a_active_fall: assert property (p_active_fall) else $error("active fall late");
endmodule // etc_exposure_ctrl

// ===== verilog/etc_defs.svh
// constants for exposure trigger control
// assumes a 50 MHz mclk
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH
`define ETC_CLK_MHZ        50
`define ETC_TBASE_US       20
`define ETC_TRIG_DLY_US    17
`define ETC_RISE_DLY_US    12
`define ETC_FALL_DLY_US    13
`define ETC_MULT_MIN       12'h001
`define ETC_PERMIT_PORT    2'h1
`define ETC_ACTIVE_PORT    2'h0
`define ETC_TRIG_PORT      2'h0
`endif

// ===== verilog/etc_pkg.sv
// types for exposure trigger control
// assumes etc_defs.svh on the include path
`include "etc_defs.svh"
package etc_pkg;
   typedef enum logic [1:0] {
      etc_idle_type_s, etc_delay_s, etc_expose_s
   } etc_state_type;
   typedef struct packed {
      logic        trig_enable;
      logic        falling_edge;
      logic        level_mode;
      logic        continuous;
      logic [1:0]  trig_source;
      logic [1:0]  permit_port;
      logic [1:0]  active_port;
      logic [11:0] multiplier;
      logic [15:0] tbase_cycles;
   } etc_cfg_type;
   typedef struct packed {
      logic [3:0] ports_out;
      logic       capture_permit_out;
      logic       exposure_active_out;
      logic       exposing;
      logic       reading;
   } etc_stat_type;
endpackage

// ===== verilog/etc_delay_line.sv
// fixed delay of a level signal, separate rise and fall latencies
// assumes one clock, inputs synchronous
`timescale 1ns/1ps
module etc_delay_line #(
   parameter int RISE_CYC = 600,
   parameter int FALL_CYC = 650
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // level in and out
   input  wire logic level_in,
   output logic      level_out
);
   typedef struct packed {
      logic        out;
      logic [15:0] cnt;
   } etc_dl_state_type;
   etc_dl_state_type s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (level_in == s_q.out) begin
         s_d.cnt = 16'h0000;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
         if (s_q.out ? (s_q.cnt >= 16'(FALL_CYC - 1)) : (s_q.cnt >= 16'(RISE_CYC - 1))) begin
            s_d.out = level_in;
            s_d.cnt = 16'h0000;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!rstn) s_q <= '0;
      else s_q <= s_d;
   end
   assign level_out = s_q.out;
endmodule // etc_delay_line

// ===== test/etc_trig_source.sv
// trigger source model driving one trigger line
// assumes callers act at the falling edge of mclk
`timescale 1ns/1ps
module etc_trig_source (
   // clock and device status
   input  wire logic mclk,
   input  wire logic permit,
   input  wire logic exposing,
   // trigger line
   output logic      pin
);
   logic act_q = 1'b1;
   logic pin_q = 1'b0;
   assign pin = pin_q;
   // ====================
   // line control
   task automatic set_polarity(input logic fall);
      act_q = ~fall;
      pin_q = fall;
   endtask
   // waits for a safe moment when asked
   task automatic press(input logic wait_safe);
      int guard;
      guard = 0;
      while (wait_safe && !(permit === 1'b1 && exposing === 1'b0) && guard < 20000) begin
         @(negedge mclk);
         guard++;
      end
      pin_q = act_q;
   endtask
   task automatic release_line();
      pin_q = ~act_q;
   endtask
endmodule // etc_trig_source

// ===== test/tb_exposure_trigger_control.sv
// self-checking bench for the exposure controller
// assumes etc_pkg and etc_trig_source compiled first
`timescale 1ns/1ps
module tb_exposure_trigger_control;
   import etc_pkg::*;
   localparam int TDLY = 4;
   localparam int RDLY = 3;
   localparam int FDLY = 3;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   etc_cfg_type cfg;
   logic [23:0] readout_cycles = 24'h00001e;
   logic [3:0]  hw_trigger_in;
   logic [3:0]  noise = 4'h0;
   logic [3:0]  ports_out;
   logic        permit, active, exposing, reading, src_pin;
   logic        exp_q = 1'b0;
   logic        act_q = 1'b0;
   logic [1:0]  pp_q = 2'h1;
   logic [1:0]  ap_q = 2'h0;
   integer      seed = 32'he516;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          len = 0;
   int          since = 0;
   int          note_q[$];
   logic [11:0] mults[6] = '{12'h001, 12'h000, 12'h014, 12'hfff, 12'h007, 12'h003};
   logic [15:0] tbs[6] = '{16'h03e8, 16'h000c, 16'h0002, 16'h0001, 16'h0005, 16'h000b};
   logic        ovls[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   always #10 mclk = ~mclk;
   always @(negedge mclk) noise <= 4'($random(seed));
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         hw_trigger_in[i] = (int'(cfg.trig_source) == i) ? src_pin : noise[i];
      end
   end
   etc_exposure_ctrl #(.TRIG_DLY_CYC(TDLY), .RISE_DLY_CYC(RDLY), .FALL_DLY_CYC(FDLY)) etc_exposure_ctrl_inst (
      .mclk(mclk), .rstn(rstn), .cfg(cfg), .readout_cycles(readout_cycles), .hw_trigger_in(hw_trigger_in),
      .ports_out(ports_out), .capture_permit_out(permit), .exposure_active_out(active),
      .exposing(exposing), .reading(reading));
   etc_trig_source etc_trig_source_inst (.mclk(mclk), .permit(permit), .exposing(exposing), .pin(src_pin));
   // ====================
   // checking and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // ====================
   // output watcher, after the drivers have settled
   always @(negedge mclk) begin
      #1;
      if (rstn) begin
         check(32'(ports_out[pp_q]), 32'(permit));
         check(32'(ports_out[ap_q]), 32'(active));
      end
      if (exposing === 1'b1) len++;
      if (exp_q && exposing === 1'b0) begin
         check(32'(len), (note_q.size() == 0) ? 32'h0 : 32'(note_q.pop_front()));
         len = 0;
      end
      since = ((exposing === 1'b1) != exp_q) ? 0 : since + 1;
      if (active === 1'b1 && !act_q) check(32'(since), 32'(RDLY + 1));
      if (active === 1'b0 && act_q) check(32'(since), 32'(FDLY + 1));
      exp_q = (exposing === 1'b1);
      act_q = (active === 1'b1);
      pp_q = cfg.permit_port;
      ap_q = cfg.active_port;
   end
   // ====================
   // one timed or level exposure, with a stray edge while permit is low
   task automatic expose(input logic [11:0] m, input logic [15:0] t, input logic ovl);
      int n;
      cfg.multiplier = m;
      cfg.tbase_cycles = t;
      etc_trig_source_inst.press(1'b1);
      note_q.push_back(((m == 12'h000) ? 1 : int'(m)) * int'(t));
      n = 0;
      while (exposing !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
         if (n == 2) check(32'(permit), 32'h0);
         if (n == 1 || n == 3) etc_trig_source_inst.release_line();
         if (n == 2) etc_trig_source_inst.press(1'b0);
      end
      check(32'(n), 32'(TDLY + 1));
      if (ovl) check(32'(reading), 32'h1);
   endtask
   initial begin
      cfg = '0;
      cfg.trig_enable = 1'b1;
      cfg.permit_port = 2'h1;
      repeat (2) @(negedge mclk);
      check(32'({ports_out, permit, exposing}), 32'h0);
      rstn = 1'b1;
      repeat (2) @(negedge mclk);
      check(32'(permit), 32'h1);
      for (int i = 0; i < 6; i++) begin
         cfg.trig_source = 2'(i);
         cfg.falling_edge = i[0];
         cfg.level_mode = (i == 5);
         cfg.permit_port = 2'($random(seed));
         cfg.active_port = cfg.permit_port ^ 2'h2;
         readout_cycles = 24'(20 + ($unsigned($random(seed)) % 10));
         etc_trig_source_inst.set_polarity(cfg.falling_edge);
         @(negedge mclk);
         expose(mults[i], tbs[i], ovls[i]);
      end
      for (int k = 0; k < 5000 && {exposing, reading, active} !== 3'h0; k++) @(negedge mclk);
      cfg.trig_enable = 1'b0;
      repeat (3) @(negedge mclk);
      check(32'(permit), 32'h0);
      etc_trig_source_inst.press(1'b0);
      repeat (20) @(negedge mclk);
      check(32'({exposing, 8'(note_q.size())}), 32'h0);
      summarize();
   end
endmodule // tb_exposure_trigger_control
